/* File: verilog/lac_tx.sv */
/*
 * lane alignment transmitter: group sync, four alignment multiframes with
 * configuration octets in the second, then user data, optionally
 * scrambled. registers on classic wishbone.
 * assumes sync_n arrives from a pin; user data from core_clk logic.
 */
// Behaviour
// - second multiframe opens with start then configuration-start 0x9C.
// - fourteen configuration octets sent, also held in readable words.
// - readable configuration words equal the built link parameters.
// - unscrambled user data follows the final alignment-end character.
// - with scrambling on, user data is scrambled after alignment.
// - interrupt stays low unless a link error is detected.
// - error bits 2 and 3 stay zero without fault; one marks error.
// - every alignment multiframe starts with 0x1C.
// - every alignment multiframe ends with 0x7C.
// - control flag set for every control character octet.
// - while sync requested, every octet is 0xBC.
`timescale 1ns/1ps
`include "lac_regs.svh"

module lac_tx #(
	parameter logic [7:0] CFG_DID = 8'h00,
	parameter logic [3:0] CFG_BID = 4'h0,
	parameter logic [4:0] CFG_LID = 5'h00,
	parameter logic [4:0] CFG_L_M1 = 5'h03,
	parameter logic [7:0] CFG_F_M1 = 8'h01,
	parameter logic [4:0] CFG_K_M1 = 5'h0F,
	parameter logic [7:0] CFG_M_M1 = 8'h03,
	parameter logic [4:0] CFG_N_M1 = 5'h0F,
	parameter logic [4:0] CFG_NT_M1 = 5'h0F,
	parameter logic [4:0] CFG_S_M1 = 5'h00,
	parameter logic [2:0] CFG_SUBCLASS = 3'h1,
	parameter logic [2:0] CFG_VERSION = 3'h1,
	parameter logic [7:0] FRAMES_PER_MF = 8'd16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic sync_n,
	input wire logic [31:0] user_data,
	input wire logic user_valid,
	output logic user_ready,
	output logic [31:0] lane_coding_bus,
	output logic [3:0] control_char_flag,
	output logic link_irq_out,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	////////////////////////////////////////////////////////////////////////
	// configuration octets, fixed at build time

	localparam logic [7:0] OCT0 = CFG_DID;
	localparam logic [7:0] OCT1 = {4'h0, CFG_BID};
	localparam logic [7:0] OCT2 = {3'h0, CFG_LID};
	localparam logic [7:0] OCT3 = {3'h0, CFG_L_M1};
	localparam logic [7:0] OCT4 = CFG_F_M1;
	localparam logic [7:0] OCT5 = {3'h0, CFG_K_M1};
	localparam logic [7:0] OCT6 = CFG_M_M1;
	localparam logic [7:0] OCT7 = {3'h0, CFG_N_M1};
	localparam logic [7:0] OCT8 = {CFG_SUBCLASS, CFG_NT_M1};
	localparam logic [7:0] OCT9 = {CFG_VERSION, CFG_S_M1};
	localparam logic [7:0] OCT10 = 8'h00;
	localparam logic [7:0] OCT11 = 8'h00;
	localparam logic [7:0] OCT12 = 8'h00;
	// checksum: octets 0 to 9 summed, mod 256
	localparam logic [7:0] OCT13 = OCT0 + OCT1 + OCT2 + OCT3 + OCT4 + OCT5 +
		OCT6 + OCT7 + OCT8 + OCT9;
	localparam logic [31:0] CAP0 = {OCT3, OCT2, OCT1, OCT0};
	localparam logic [31:0] CAP1 = {OCT7, OCT6, OCT5, OCT4};
	localparam logic [31:0] CAP2 = {OCT11, OCT10, OCT9, OCT8};
	localparam logic [31:0] CAP3 = {16'h0, OCT13, OCT12};
	localparam logic [31:0] CAP4 = {24'h0, FRAMES_PER_MF};
	localparam logic [31:0] CAP5 = {27'h0, CFG_L_M1};
	localparam logic [7:0] WORDS_PER_MF = FRAMES_PER_MF;

	////////////////////////////////////////////////////////////////////////
	// sync_n input synchroniser

	logic sync_meta_q;
	logic sync_req_q;

	// only sync_req_q is read; the first stage may be metastable

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_meta_q <= 1'b0;
			sync_req_q <= 1'b0;
		end else if (clk_en) begin
			sync_meta_q <= ~sync_n;
			sync_req_q <= sync_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic [1:0] ctrl_q;
	logic [3:0] err_q;
	lac_pkg::lac_state_t state_q;
	lac_pkg::lac_state_t state_d;
	logic [1:0] mf_q;
	logic [7:0] word_q;
	logic scr_on_q;

	wire link_en = ctrl_q[`LAC_CTRL_EN_BIT];
	wire mf_last = (word_q == WORDS_PER_MF - 8'd1);
	wire ilas_done = (state_q == lac_pkg::LAC_ST_ILAS) && mf_last &&
		(mf_q == `LAC_ILAS_MF);
	wire in_data = (state_q == lac_pkg::LAC_ST_DATA);
	// errors only count while user data is flowing
	wire sync_lost = in_data && sync_req_q;
	wire underrun = in_data && !user_valid && !sync_req_q;

	always_comb begin
		case (state_q)
			lac_pkg::LAC_ST_IDLE:
				state_d = link_en ? lac_pkg::LAC_ST_SYNC : lac_pkg::LAC_ST_IDLE;
			lac_pkg::LAC_ST_SYNC:
				state_d = sync_req_q ? lac_pkg::LAC_ST_SYNC : lac_pkg::LAC_ST_ILAS;
			lac_pkg::LAC_ST_ILAS:
				state_d = ilas_done ? lac_pkg::LAC_ST_DATA : lac_pkg::LAC_ST_ILAS;
			lac_pkg::LAC_ST_DATA:
				state_d = lac_pkg::LAC_ST_DATA;
			default:
				state_d = lac_pkg::LAC_ST_IDLE;
		endcase
		if (!link_en) begin
			state_d = lac_pkg::LAC_ST_IDLE;
		end else if (sync_req_q && state_q != lac_pkg::LAC_ST_IDLE) begin
			state_d = lac_pkg::LAC_ST_SYNC;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= lac_pkg::LAC_ST_IDLE;
			mf_q <= 2'h0;
			word_q <= 8'h0;
			scr_on_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			if (state_d != lac_pkg::LAC_ST_ILAS ||
				state_q != lac_pkg::LAC_ST_ILAS) begin
				mf_q <= 2'h0;
				word_q <= 8'h0;
			end else if (mf_last) begin
				word_q <= 8'h0;
				mf_q <= mf_q + 2'h1;
			end else begin
				word_q <= word_q + 8'h1;
			end
			// scramble mode latched when alignment starts
			// a later change of the scramble bit waits for the next resync
			if (state_q == lac_pkg::LAC_ST_SYNC) begin
				scr_on_q <= ctrl_q[`LAC_CTRL_SCR_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lane word selection

	logic [31:0] scr_out;
	lac_pkg::lac_lane_word_t ilas_w;
	lac_pkg::lac_lane_word_t next_w;

	lac_scrambler u_scr (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.adv(clk_en && in_data && user_valid),
		.din(user_data),
		.dout(scr_out)
	);

	// octet 0 of the word is sent first (bits 7:0)
	always_comb begin
		ilas_w.data = {user_data[31:8], 8'h00};
		ilas_w.kflag = 4'h0;
		ilas_w.data = {word_q, 6'h0, mf_q, word_q, 6'h0, mf_q};
		if (word_q == 8'h0) begin
			ilas_w.data[7:0] = `LAC_K_MF;
			ilas_w.kflag[0] = 1'b1;
		end
		if (mf_q == 2'h1 && word_q == 8'h0) begin
			ilas_w.data[15:8] = `LAC_K_CFG;
			ilas_w.kflag[1] = 1'b1;
			ilas_w.data[31:16] = CAP0[15:0];
		end
		if (mf_q == 2'h1) begin
			case (word_q)
				8'h01: ilas_w.data = {CAP1[15:0], CAP0[31:16]};
				8'h02: ilas_w.data = {CAP2[15:0], CAP1[31:16]};
				8'h03: ilas_w.data = {CAP3[15:0], CAP2[31:16]};
				default: ;
			endcase
		end
		if (mf_last) begin
			ilas_w.data[31:24] = `LAC_K_END;
			ilas_w.kflag[3] = 1'b1;
		end
	end

	always_comb begin
		next_w.data = {4{`LAC_K_GRP}};
		next_w.kflag = 4'h0;
		case (state_q)
			lac_pkg::LAC_ST_SYNC: begin
				next_w.data = {4{`LAC_K_GRP}};
				next_w.kflag = 4'hF;
			end
			lac_pkg::LAC_ST_ILAS: begin
				next_w = ilas_w;
			end
			lac_pkg::LAC_ST_DATA: begin
				// user data right after last end character
				next_w.data = scr_on_q ? scr_out : user_data;
				next_w.kflag = 4'h0;
			end
			default: begin
				next_w.data = 32'h0;
				next_w.kflag = 4'h0;
			end
		endcase
		if (sync_req_q) begin
			next_w.data = {4{`LAC_K_GRP}};
			next_w.kflag = 4'hF;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lane_coding_bus <= 32'h0;
			control_char_flag <= 4'h0;
			user_ready <= 1'b0;
		end else if (clk_en) begin
			lane_coding_bus <= next_w.data;
			control_char_flag <= next_w.kflag;
			// ready marks the cycle whose user word the lane takes
			user_ready <= (state_d == lac_pkg::LAC_ST_DATA);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone slave

	lac_pkg::lac_wb_req_t req;
	assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i};

	// one ack per request: a held strobe is not taken twice
	wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_ctrl = acc && req.we && req.sel[0] && (req.adr == `LAC_OFS_CTRL);
	wire wr_err = acc && req.we && req.sel[0] && (req.adr == `LAC_OFS_ERR);
	wire [3:0] err_set = {underrun, sync_lost, 2'b00};
	// capture words come from build-time constants only
	wire [31:0] rd_mux =
		(req.adr == `LAC_OFS_CAP0) ? CAP0 :
		(req.adr == `LAC_OFS_CAP1) ? CAP1 :
		(req.adr == `LAC_OFS_CAP2) ? CAP2 :
		(req.adr == `LAC_OFS_CAP3) ? CAP3 :
		(req.adr == `LAC_OFS_CAP4) ? CAP4 :
		(req.adr == `LAC_OFS_CAP5) ? CAP5 :
		(req.adr == `LAC_OFS_CTRL) ? {30'h0, ctrl_q} :
		(req.adr == `LAC_OFS_ERR) ? {28'h0, err_q} :
		(req.adr == `LAC_OFS_STAT) ? {26'h0, mf_q, state_q} : 32'h0;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `LAC_CTRL_RESET;
			err_q <= 4'h0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			link_irq_out <= 1'b0;
		end else if (clk_en) begin
			wb_ack_o <= acc;
			wb_dat_o <= acc ? rd_mux : 32'h0;
			if (wr_ctrl) begin
				ctrl_q <= req.dat[1:0];
			end
			// error bits, set wins over write-one-clear
			err_q <= (err_q & ~(wr_err ? req.dat[3:0] : 4'h0)) | err_set;
			// irq only from a detected error
			link_irq_out <= |((err_q & ~(wr_err ? req.dat[3:0] : 4'h0)) |
				err_set);
		end
	end

	// capture words have no write path

endmodule // lac_tx

/* File: verilog/lac_regs.svh */
/*
 * register offsets, field positions, reset values and link constants
 * for the lane alignment transmitter. assumes a word-addressed wishbone
 * slave with byte addresses on adr.
 */
`ifndef LAC_REGS_SVH
`define LAC_REGS_SVH

`define LAC_OFS_CAP0 8'h00
`define LAC_OFS_CAP1 8'h04
`define LAC_OFS_CAP2 8'h08
`define LAC_OFS_CAP3 8'h0C
`define LAC_OFS_CAP4 8'h10
`define LAC_OFS_CAP5 8'h14
`define LAC_OFS_CTRL 8'h18
`define LAC_OFS_ERR 8'h1C
`define LAC_OFS_STAT 8'h20

`define LAC_CTRL_EN_BIT 0
`define LAC_CTRL_SCR_BIT 1
`define LAC_ERR_SYNC_BIT 2
`define LAC_ERR_UNDER_BIT 3
`define LAC_CTRL_RESET 2'h0

`define LAC_K_GRP 8'hBC
`define LAC_K_MF 8'h1C
`define LAC_K_CFG 8'h9C
`define LAC_K_END 8'h7C
`define LAC_ILAS_MF 2'h3
`define LAC_CFG_OCTETS 14
`define LAC_SCR_SEED 15'h7F80

`endif

/* File: verilog/lac_pkg.sv */
/*
 * types shared by the lane alignment transmitter files.
 * assumes lac_regs.svh is available on the include path.
 */
package lac_pkg;

	typedef enum logic [3:0] {
		LAC_ST_IDLE = 4'h1,
		LAC_ST_SYNC = 4'h2,
		LAC_ST_ILAS = 4'h4,
		LAC_ST_DATA = 4'h8
	} lac_state_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] kflag;
	} lac_lane_word_t;

	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
	} lac_wb_req_t;

endpackage

/* File: verilog/lac_scrambler.sv */
/*
 * self-synchronous 1 + x^14 + x^15 scrambler, one 32-bit word a cycle.
 * assumes the caller holds adv low while the word is not consumed.
 */
`timescale 1ns/1ps
`include "lac_regs.svh"

module lac_scrambler (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic adv,
	input wire logic [31:0] din,
	output logic [31:0] dout
);

	logic [14:0] state_q;
	logic [14:0] state_d;
	logic [31:0] mix;

	// msb first, each output bit feeds the state
	always_comb begin
		state_d = state_q;
		mix = 32'h0;
		for (int i = 31; i >= 0; i--) begin
			mix[i] = din[i] ^ state_d[14] ^ state_d[13];
			state_d = {state_d[13:0], mix[i]};
		end
	end

	assign dout = mix;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= `LAC_SCR_SEED;
		end else if (adv) begin
			state_q <= state_d;
		end
	end

endmodule // lac_scrambler

/* File: sim/lac_tx_sva.sv */
/* port assertions for lac_tx.
   assumes clk_en drops only while the bus is idle and sync is released. */
`timescale 1ns/1ps
module lac_tx_sva (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic sync_n,
	input wire logic user_ready,
	input wire logic [31:0] lane_coding_bus,
	input wire logic [3:0] control_char_flag,
	input wire logic link_irq_out,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////
	a_ack_next: assert property ( // bus answer
		wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property ( // bus answer
		wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_dat_idle: assert property ( // bus answer
		!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
	a_sync_fill: assert property (
		!sync_n [*4] |=> lane_coding_bus == 32'h0 ||
		(lane_coding_bus == 32'hBCBCBCBC && control_char_flag == 4'hF))
		else $error("no fill");
	a_flag_value: assert property (
		control_char_flag[0] |->
		lane_coding_bus[7:0] inside {8'hBC, 8'h1C, 8'h9C, 8'h7C})
		else $error("bad control octet");
	a_cfg_start: assert property (
		control_char_flag[1] && lane_coding_bus[15:8] == 8'h9C |->
		control_char_flag[0] && lane_coding_bus[7:0] == 8'h1C)
		else $error("bad config start");
	a_data_noflag: assert property (
		user_ready && $past(user_ready) |-> control_char_flag == 4'h0)
		else $error("flag in data");
	a_irq_cause: assert property (
		$rose(link_irq_out) |-> $past(user_ready) || $past(user_ready, 2))
		else $error("irq without fault");
endmodule // lac_tx_sva

bind lac_tx lac_tx_sva lac_tx_sva_i (.core_clk(core_clk),
	.arst_n(arst_n), .clk_en(clk_en), .sync_n(sync_n),
	.user_ready(user_ready), .lane_coding_bus(lane_coding_bus),
	.control_char_flag(control_char_flag), .link_irq_out(link_irq_out),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o));

/* File: sim/lac_rx_model.sv */
/* receiving end: requests sync, follows alignment, captures octets.
   assumes W equals the transmitter's words per multiframe. */
`timescale 1ns/1ps
module lac_rx_model #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic req_sync,
	input wire logic [31:0] lane,
	input wire logic [3:0] kf,
	output logic sync_n
);
	logic [7:0] cfg [14];
	logic [31:0] first_data;
	int idx;
	int errs;
	int w;
	int n;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_n <= 1'b0;
			idx <= -1;
			errs <= 0;
		end else begin
			sync_n <= !req_sync;
			w = (idx < 0 && kf[0] && lane[7:0] == 8'h1C) ? 0 : idx;
			if (!sync_n)
				w = -1;
			if (w >= 0 && w < 4 * W) begin
				if (w % W == 0 && !(kf[0] && lane[7:0] == 8'h1C))
					errs <= errs + 1;
				if (w % W == W - 1 && !(kf[3] && lane[31:24] == 8'h7C))
					errs <= errs + 1;
				if (w == W && !(kf[1] && lane[15:8] == 8'h9C))
					errs <= errs + 1;
				for (int j = 0; j < 4; j++) begin
					n = (w - W) * 4 + j - 2;
					if (n >= 0 && n < 14)
						cfg[n] <= lane[8*j+:8];
				end
			end
			if (w == 4 * W)
				first_data <= lane;
			idx <= (w >= 0 && w <= 4 * W) ? w + 1 : w;
		end
	end
endmodule // lac_rx_model

/* File: sim/lac_tx_bench.sv */
/* bench for lac_tx with a receiving end model.
   assumes lac_regs.svh on the include path. */
`timescale 1ns/1ps
`include "lac_regs.svh"
module lac_tx_bench;
	localparam logic [31:0] PAT = 32'h13579BDF;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic wen = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic req = 1'b1;
	logic en = 1'b1;
	logic uv = 1'b1;
	logic [3:0] sel = 4'hF;
	logic [31:0] ud = PAT;
	logic sync_n, rdy, irq, ack;
	logic [31:0] lane, rdat, q, e;
	logic [3:0] kf;
	int bad_count = 0;
	int samples_checked = 0;
	always #50 core_clk = ~core_clk;
	lac_tx #(.CFG_DID(8'hA5), .CFG_BID(4'h6), .CFG_LID(5'h0B),
		.CFG_L_M1(5'h01), .FRAMES_PER_MF(8'h08)) lac_tx_i (
		.core_clk(core_clk), .arst_n(arst_n), .clk_en(en),
		.sync_n(sync_n), .user_data(ud), .user_valid(uv),
		.user_ready(rdy), .lane_coding_bus(lane),
		.control_char_flag(kf), .link_irq_out(irq), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(wen), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack));
	lac_rx_model #(.W(8)) lac_rx_model_i (.core_clk(core_clk),
		.arst_n(arst_n), .req_sync(req), .lane(lane), .kf(kf),
		.sync_n(sync_n));
	////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, x);
		samples_checked++;
		if (s !== x) begin
			bad_count++;
			$display("wrong value %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		wen <= we;
		adr <= a;
		wdat <= d;
		@(posedge core_clk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 20)
			bad_count++;
		q = rdat;
		cyc <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] m, x);
		wb(1'b0, a, 32'h0);
		chk(nm, q & m, x & m);
	endtask
	task automatic link_up();
		int n;
		n = 0;
		req <= 1'b0;
		while (lac_rx_model_i.idx <= 32 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 400)
			bad_count++;
	endtask
	task automatic conclude();
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		bad_count++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		wb(1'b1, `LAC_OFS_CTRL, 32'h1);
		repeat (8) @(posedge core_clk);
		chk("fill", lane, 32'hBCBCBCBC);
		chk("fillk", {28'h0, kf}, 32'hF);
		link_up();
		chk("rx", 32'(lac_rx_model_i.errs), 32'h0);
		chk("first", lac_rx_model_i.first_data, PAT);
		chk("rdy", {31'h0, rdy}, 32'h1);
		for (int r = 0; r < 4; r++) begin
			for (int j = 0; j < 4; j++)
				e[8*j+:8] = lac_rx_model_i.cfg[4*r+j];
			rdc("cap", 8'(4 * r), r == 3 ? 32'hFFFF : '1, e);
		end
		rdc("cap0", `LAC_OFS_CAP0, 32'h1F1F0FFF, 32'h010B06A5);
		rdc("cap4", `LAC_OFS_CAP4, 32'hFF, 32'h08);
		rdc("cap5", `LAC_OFS_CAP5, 32'h1F, 32'h01);
		rdc("cap1", `LAC_OFS_CAP1, 32'h1FFF1FFF, 32'h0F030F01);
		rdc("cap2", `LAC_OFS_CAP2, 32'h0000FFFF, 32'h0000202F);
		rdc("err", `LAC_OFS_ERR, 32'hC, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		// clk_en low: the lane must keep the word taken before the freeze
		e = PAT;
		ud <= ~PAT;
		en <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("freeze", lane, e);
		en <= 1'b1;
		ud <= PAT;
		uv <= 1'b0;
		@(posedge core_clk);
		uv <= 1'b1;
		@(posedge core_clk);
		rdc("under", `LAC_OFS_ERR, 32'h8, 32'h8);
		chk("irq", {31'h0, irq}, 32'h1);
		wb(1'b1, `LAC_OFS_ERR, 32'h8);
		rdc("uclr", `LAC_OFS_ERR, 32'hC, 32'h0);
		wb(1'b1, `LAC_OFS_CAP0, 32'hFFFFFFFF);
		rdc("ro", `LAC_OFS_CAP0, 32'h1F1F0FFF, 32'h010B06A5);
		rdc("hole", 8'h24, 32'hFFFFFFFF, 32'h0);
		sel <= 4'h0;
		wb(1'b1, `LAC_OFS_CTRL, 32'h0);
		sel <= 4'hF;
		rdc("sel", `LAC_OFS_CTRL, 32'h3, 32'h1);
		wb(1'b1, `LAC_OFS_CTRL, 32'h3);
		req <= 1'b1;
		repeat (8) @(posedge core_clk);
		rdc("lost", `LAC_OFS_ERR, 32'h4, 32'h4);
		chk("rdy0", {31'h0, rdy}, 32'h0);
		chk("irq", {31'h0, irq}, 32'h1);
		wb(1'b1, `LAC_OFS_ERR, 32'hC);
		rdc("clr", `LAC_OFS_ERR, 32'hC, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		link_up();
		chk("rx", 32'(lac_rx_model_i.errs), 32'h0);
		chk("scr", {31'h0, lac_rx_model_i.first_data !== PAT}, 32'h1);
		conclude();
	end
endmodule // lac_tx_bench
